// file: hdl/cvr_regs.svh
`ifndef CVR_REGS_SVH
`define CVR_REGS_SVH

// ****************************************************************
// Register indices; the byte address is four times the index
// ****************************************************************
`define CVR_IDX_INTCTL   8'h0b
`define CVR_IDX_PFLAGS   8'h0c
`define CVR_IDX_CMPCTL   8'h1f
`define CVR_IDX_PADIR    8'h85
`define CVR_IDX_PENABLES 8'h8c
`define CVR_IDX_REFCTL   8'h9f
`define CVR_IDX_IRQSTAT  8'ha0
`define CVR_IDX_IRQMASK  8'ha1

// ****************************************************************
// Reset values and writable masks
// ****************************************************************
`define CVR_RST_PADIR    8'h1f
`define CVR_RST_ZERO     8'h00
`define CVR_MASK_CMPCTL  8'h0f
`define CVR_MASK_REFCTL  8'hef
`define CVR_MASK_PADIR   8'h1f
`define CVR_MASK_INTCTL  8'hc0
`define CVR_MASK_IRQ     8'h03

// ****************************************************************
// Field positions
// ****************************************************************
`define CVR_BIT_CHG      6
`define CVR_BIT_GIE      7
`define CVR_BIT_PERIPHERAL_INTERRUPT_ENABLE     6
`define CVR_BIT_REN      7
`define CVR_BIT_ROE      6
`define CVR_BIT_RNG      5
`define CVR_BIT_PIN      2
`define CVR_BIT_CIS      3
`define CVR_MODE_MSB     2
`define CVR_LVL_MSB      3
`define CVR_MODE_INTREF  3'h2
`define CVR_EV_CHG       0
`define CVR_EV_CMPWR     1

`endif

// file: hdl/cvr_pkg.sv
package cvr_pkg;
  typedef enum logic [1:0] {
    CVR_IDLE   = 2'b00,
    CVR_ACCESS = 2'b01
  } cvr_apb_t;

  typedef struct packed {
    cvr_apb_t   ph;
    logic [7:0] cmpctl;
    logic [7:0] refctl;
    logic [7:0] padir;
    logic [7:0] intctl;
    logic       chg;
    logic       cmpen;
    logic [1:0] latched;
    logic [1:0] irqstat;
    logic [1:0] irqmask;
    logic [31:0] rdata;
  } cvr_state_t;
endpackage

// file: hdl/cvr_sync2.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// Two-stage synchroniser for comparator results
// ****************************************************************
module cvr_sync2 (
  input  wire logic       pclk,    // Clock
  input  wire logic       presetn, // Async reset
  input  wire logic [1:0] d_in,    // Asynchronous inputs
  output logic      [1:0] q_out    // Synchronised outputs
);
  logic [1:0] meta_ff;
  logic [1:0] sync_ff;

  // First stage only feeds second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= 2'h0;
      sync_ff <= 2'h0;
    end else begin
      meta_ff <= d_in;
      sync_ff <= meta_ff;
    end
  end

  assign q_out = sync_ff;
endmodule
`default_nettype wire

// file: hdl/cvr_ladder.sv
`timescale 1ns/1ns
`default_nettype none
`include "cvr_regs.svh"
// ****************************************************************
// Ladder tap decode from reference control
// ****************************************************************
module cvr_ladder
  import cvr_pkg::*;
(
  input  wire logic [7:0] refctl,     // Reference control value
  input  wire logic       pin_dir,    // Port A bit 2 direction
  output logic            ladder_en,  // Ladder powered
  output logic            range_low,  // Range select
  output logic      [3:0] tap_sel,    // Tap select
  output logic            pin_connect // Reference to pin switch
);
  // Only the pin switch gates on enable; range and tap outputs follow refctl when off
  assign ladder_en   = refctl[`CVR_BIT_REN];                              // [R03]
  assign range_low   = refctl[`CVR_BIT_RNG];                              // [R04] [R05]
  assign tap_sel     = refctl[`CVR_LVL_MSB:0];                            // [R02]
  assign pin_connect = refctl[`CVR_BIT_ROE] & pin_dir & refctl[`CVR_BIT_REN]; // [R11]
endmodule
`default_nettype wire

// file: hdl/cvr_top.sv
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "cvr_regs.svh"
// How it works
// [R01] A result change during a control register read may miss the flag.
// [R02] Reference picks one of sixteen ladder taps in each range.
// [R03] Clearing the enable bit powers the ladder down.
// [R04] Range bit one: output is level over 24 times supply.
// [R05] Range bit zero: quarter supply plus level over 32 times supply.
// [R06] Software waits for settling after changing the level.
// [R07] Every reset clears enable, pin output, range and level bits.
// [R08] Wake from sleep keeps reference control contents.
// [R09] Software disables reference before sleep to save current.
// [R10] Reference works regardless of comparator mode.
// [R11] Pin connects only when direction is input and pin output set.
// [R12] Unimplemented bits read zero; unchanged bits kept on warm reset.
// [R13] Mode 010 routes internal reference to both non-inverting inputs.
// [R14] Change flag sets when results differ from latched; access relatches.
// [R15] Reference write updates ladder outputs on the completing edge.
module cvr_top
  import cvr_pkg::*;
(
  input  wire logic        pclk,          // APB clock
  input  wire logic        presetn,       // Async reset, active low
  input  wire logic        psel,          // APB select
  input  wire logic        penable,       // APB enable
  input  wire logic        pwrite,        // APB direction
  input  wire logic [31:0] paddr,         // APB byte address
  input  wire logic [31:0] pwdata,        // APB write data
  input  wire logic [3:0]  pstrb,         // APB byte strobes
  output logic             pready,        // APB ready
  output logic      [31:0] prdata,        // APB read data
  output logic             pslverr,       // APB error
  input  wire logic [1:0]  cmp_result,    // Raw comparator outputs
  output logic             ladder_en,     // Ladder power
  output logic             range_low,     // Range select bit
  output logic      [3:0]  tap_sel,       // Tap select
  output logic             pin_connect,   // Reference to pin switch
  output logic      [2:0]  cmp_mode,      // Comparator mode field
  output logic             cmp_in_switch, // Comparator input switch
  output logic             int_ref_sel,   // Internal reference to inputs
  output logic             cpu_irq,       // Core interrupt request
  output logic             irq            // Block interrupt, level
);
  // ****************************************************************
  // State and decode
  // ****************************************************************
  cvr_state_t st_ff;
  cvr_state_t nxt_st;
  logic [1:0] cmp_sync;
  logic       setup;
  logic       access;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] idx;
  logic       mapped;
  logic [7:0] rd_byte;
  logic [1:0] ev;

  // Merge writable bits only where the low byte lane is strobed
  function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                       input logic [7:0] mask, input logic lane);
    merge = lane ? ((old_v & ~mask) | (new_v & mask)) : old_v;
  endfunction

  // Address to index, word aligned only
  function automatic logic is_addr(input logic [31:0] a, input logic [7:0] i);
    is_addr = (a[31:10] == 22'h0) && (a[9:2] == i) && (a[1:0] == 2'h0);
  endfunction

  cvr_sync2 u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d_in    (cmp_result),
    .q_out   (cmp_sync)
  );

  cvr_ladder u_ladder (
    .refctl      (st_ff.refctl),
    .pin_dir     (st_ff.padir[`CVR_BIT_PIN]),
    .ladder_en   (ladder_en),
    .range_low   (range_low),
    .tap_sel     (tap_sel),
    .pin_connect (pin_connect)
  );

  // Bus phase qualifiers, zero wait states
  assign setup  = psel & ~penable;
  assign access = psel & penable;
  assign wr_en  = access & pwrite;
  assign rd_en  = access & ~pwrite;
  assign mapped = is_addr(paddr, `CVR_IDX_INTCTL) | is_addr(paddr, `CVR_IDX_PFLAGS)
                | is_addr(paddr, `CVR_IDX_CMPCTL) | is_addr(paddr, `CVR_IDX_PADIR)
                | is_addr(paddr, `CVR_IDX_PENABLES) | is_addr(paddr, `CVR_IDX_REFCTL)
                | is_addr(paddr, `CVR_IDX_IRQSTAT) | is_addr(paddr, `CVR_IDX_IRQMASK);
  assign idx    = paddr[9:2];

  // Read mux; unimplemented bits read zero
  always_comb begin
    rd_byte = `CVR_RST_ZERO;
    case (idx)
      `CVR_IDX_CMPCTL:   rd_byte = {cmp_sync, 2'h0, st_ff.cmpctl[`CVR_BIT_CIS:0]}; // [R12]
      `CVR_IDX_REFCTL:   rd_byte = st_ff.refctl & `CVR_MASK_REFCTL;          // [R12]
      `CVR_IDX_PADIR:    rd_byte = st_ff.padir & `CVR_MASK_PADIR;
      `CVR_IDX_INTCTL:   rd_byte = st_ff.intctl & `CVR_MASK_INTCTL;
      `CVR_IDX_PFLAGS:   rd_byte = {1'b0, st_ff.chg, 6'h0};
      `CVR_IDX_PENABLES: rd_byte = {1'b0, st_ff.cmpen, 6'h0};
      `CVR_IDX_IRQSTAT:  rd_byte = {6'h0, st_ff.irqstat};
      `CVR_IDX_IRQMASK:  rd_byte = {6'h0, st_ff.irqmask};
      default:           rd_byte = `CVR_RST_ZERO;
    endcase
    if (!mapped) begin
      rd_byte = `CVR_RST_ZERO;
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    nxt_st = st_ff;
    ev     = 2'h0;
    case (st_ff.ph)
      CVR_IDLE:   nxt_st.ph = setup ? CVR_ACCESS : CVR_IDLE;
      CVR_ACCESS: nxt_st.ph = setup ? CVR_ACCESS : CVR_IDLE;
      default:    nxt_st.ph = CVR_IDLE;
    endcase

    // Mismatch against latched results raises the change flag
    if (cmp_sync != st_ff.latched) begin
      ev[`CVR_EV_CHG] = 1'b1;
    end

    // Read data captured at setup so it stands through the access phase
    if (setup && !pwrite && mapped) begin
      nxt_st.rdata = {24'h0, rd_byte};
    end

    if (wr_en && mapped) begin
      case (idx)
        `CVR_IDX_CMPCTL: begin
          nxt_st.cmpctl = merge(st_ff.cmpctl, pwdata[7:0], `CVR_MASK_CMPCTL, pstrb[0]);
          ev[`CVR_EV_CMPWR] = pstrb[0];
        end
        `CVR_IDX_REFCTL:   nxt_st.refctl = merge(st_ff.refctl, pwdata[7:0],
                                                 `CVR_MASK_REFCTL, pstrb[0]); // [R15] [R10]
        `CVR_IDX_PADIR:    nxt_st.padir  = merge(st_ff.padir, pwdata[7:0],
                                                 `CVR_MASK_PADIR, pstrb[0]);
        `CVR_IDX_INTCTL:   nxt_st.intctl = merge(st_ff.intctl, pwdata[7:0],
                                                 `CVR_MASK_INTCTL, pstrb[0]);
        `CVR_IDX_PFLAGS:   nxt_st.chg    = pstrb[0] ? pwdata[`CVR_BIT_CHG] : st_ff.chg;
        `CVR_IDX_PENABLES: nxt_st.cmpen  = pstrb[0] ? pwdata[`CVR_BIT_CHG] : st_ff.cmpen;
        `CVR_IDX_IRQMASK:  nxt_st.irqmask = pstrb[0] ? 2'(pwdata[7:0] & `CVR_MASK_IRQ)
                                                     : st_ff.irqmask;
        default:           nxt_st.padir  = st_ff.padir;
      endcase
    end

    // Any access of comparator control relatches the results it returns
    if (setup && mapped && (idx == `CVR_IDX_CMPCTL)) begin
      nxt_st.latched = cmp_sync;                      // [R14]
      ev[`CVR_EV_CHG] = 1'b0;                         // [R01]
    end

    // Hardware set wins over software clear
    if (ev[`CVR_EV_CHG]) begin
      nxt_st.chg = 1'b1;                              // [R14]
    end

    // Sticky status; a read clears only the bits it returned, set wins
    if (rd_en && mapped && (idx == `CVR_IDX_IRQSTAT)) begin
      nxt_st.irqstat = st_ff.irqstat & ~st_ff.rdata[1:0];
    end
    nxt_st.irqstat = nxt_st.irqstat | ev;
  end

  // ****************************************************************
  // State register; reset clears all control bits except padir, which loads 8'h1f
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff         <= '0;                            // [R07]
      st_ff.padir   <= `CVR_RST_PADIR;
      st_ff.refctl  <= `CVR_RST_ZERO;                 // [R07] [R08]
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign pready        = 1'b1;
  assign pslverr       = access & ~mapped;
  assign prdata        = st_ff.rdata;
  assign cmp_mode      = st_ff.cmpctl[`CVR_MODE_MSB:0];
  assign cmp_in_switch = st_ff.cmpctl[`CVR_BIT_CIS];
  assign int_ref_sel   = (st_ff.cmpctl[`CVR_MODE_MSB:0] == `CVR_MODE_INTREF); // [R13]
  assign cpu_irq       = st_ff.chg & st_ff.cmpen & st_ff.intctl[`CVR_BIT_GIE]
                       & st_ff.intctl[`CVR_BIT_PERIPHERAL_INTERRUPT_ENABLE];
  assign irq           = |(st_ff.irqstat & st_ff.irqmask);
endmodule
`default_nettype wire

// file: verif/cvr_top_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module cvr_chk (
  input wire logic        pclk,          // Clock
  input wire logic        presetn,       // Reset, low
  input wire logic        psel,          // Select
  input wire logic        penable,       // Enable
  input wire logic        pwrite,        // Direction
  input wire logic [31:0] paddr,         // Address
  input wire logic [31:0] pwdata,        // Write data
  input wire logic [3:0]  pstrb,         // Strobes
  input wire logic        pready,        // Ready
  input wire logic [31:0] prdata,        // Read data
  input wire logic        pslverr,       // Error
  input wire logic [1:0]  cmp_result,    // Results
  input wire logic        ladder_en,     // Ladder power
  input wire logic        range_low,     // Range
  input wire logic [3:0]  tap_sel,       // Tap
  input wire logic        pin_connect,   // Pin switch
  input wire logic [2:0]  cmp_mode,      // Mode
  input wire logic        cmp_in_switch, // Input switch
  input wire logic        int_ref_sel,   // Internal ref
  input wire logic        cpu_irq,       // Core irq
  input wire logic        irq            // Block irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access phase qualifiers
  wire acc = psel & penable;
  wire wr0 = acc & pwrite & pstrb[0];
  a_ref_write: assert property (wr0 && paddr == 32'h27c |=> ladder_en == $past(pwdata[7])
    && range_low == $past(pwdata[5]) && tap_sel == $past(pwdata[3:0]))
    else $error("reference outputs differ from written value");
  a_mode_write: assert property (wr0 && paddr == 32'h7c |=> cmp_mode == $past(pwdata[2:0])
    && $stable(tap_sel) && $stable(ladder_en) && $stable(range_low))
    else $error("comparator write disturbed reference or mode wrong");
  a_intref_mode: assert property (int_ref_sel == (cmp_mode == 3'h2))
    else $error("internal reference select wrong");
  a_pin_gate: assert property (pin_connect |-> ladder_en)
    else $error("pin connected with ladder off");
  a_reset_clear: assert property ($rose(presetn) |-> !ladder_en && !range_low
    && tap_sel == 4'h0 && !pin_connect)
    else $error("reference not cleared by reset");
  a_ready_now: assert property (acc |-> pready)
    else $error("ready low in access phase");
  a_unmapped_err: assert property (acc && paddr == 32'h3f0 |-> pslverr)
    else $error("no error on unmapped address");
  a_rdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved without a read setup");
  c_ref_wr: cover property (wr0 && paddr == 32'h27c);
  c_mode: cover property (int_ref_sel);
  c_irq: cover property ($rose(cpu_irq));
endmodule
bind cvr_top cvr_chk chk_u (.*);
`default_nettype wire

// file: verif/cvr_analog_model.sv
`timescale 1ns/1ns
`default_nettype none
module cvr_analog_model (
  input wire logic       ladder_en,   // Ladder power
  input wire logic       range_low,   // Range
  input wire logic [3:0] tap_sel,     // Tap
  input wire logic       int_ref_sel, // Internal ref
  input wire logic [6:0] vin1,        // Pin level, Vdd/96
  input wire logic [6:0] vin2,        // Pin level, Vdd/96
  output logic     [1:0] cmp_result,  // Results
  output logic     [6:0] vref         // Ladder level, Vdd/96
);
  // Ladder level and comparators
  always_comb begin
    vref = !ladder_en ? 7'h00 : range_low ? {1'b0, tap_sel, 2'b00} : 7'(24 + 3 * tap_sel);
    cmp_result = int_ref_sel ? {vref > vin2, vref > vin1} : 2'b00;
  end
endmodule
`default_nettype wire

// file: verif/cvr_top_test.sv
`timescale 1ns/1ns
`default_nettype none
module cvr_top_test;
  localparam logic [31:0] RC = 32'h27c, PD = 32'h214, CC = 32'h7c, PF = 32'h30;
  localparam logic [31:0] IC = 32'h2c, PE = 32'h230, IS = 32'h280, IM = 32'h284;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic ladder_en, range_low, pin_connect, cmp_in_switch, int_ref_sel, cpu_irq, irq;
  logic [31:0] paddr, pwdata, prdata;
  logic [3:0] pstrb, tap_sel;
  logic [2:0] cmp_mode;
  logic [1:0] cmp_result;
  logic [6:0] vref, vin1, vin2;
  logic [7:0] rd;
  logic hi;
  int failures, num_checks;
  cvr_top dut_u (.*);
  cvr_analog_model ana_u (.*);
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; response and read data taken at the access edge
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    err = pslverr;
    rd = prdata[7:0];
    hi = |prdata[31:8];
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdchk(input logic [31:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    check(rd, e);
    check(8'(hi), 8'h00);
  endtask
  task automatic t_reset();
    rdchk(RC, 8'h00);
    rdchk(PD, 8'h1f);
    rdchk(CC, 8'h00);
    rdchk(PF, 8'h00);
    $display("t_reset done");
  endtask
  task automatic t_ref();
    xfer(1'b1, RC, 8'hff);
    rdchk(RC, 8'hef);
    for (int r = 0; r < 2; r++) begin
      for (int t = 0; t < 16; t++) begin
        xfer(1'b1, RC, 8'(128 + 32 * r + t));
        check(8'(tap_sel), 8'(t));
        check(8'(vref), 8'(r ? 4 * t : 24 + 3 * t));
      end
    end
    xfer(1'b1, RC, 8'h00);
    check(8'(ladder_en), 8'h00);
    $display("t_ref done");
  endtask
  task automatic t_pin();
    xfer(1'b1, RC, 8'hc0);
    check(8'(pin_connect), 8'h01);
    xfer(1'b1, PD, 8'hfb);
    check(8'(pin_connect), 8'h00);
    rdchk(PD, 8'h1b);
    xfer(1'b1, PD, 8'h1f);
    xfer(1'b1, RC, 8'h40);
    check(8'(pin_connect), 8'h00);
    $display("t_pin done");
  endtask
  task automatic t_mode();
    xfer(1'b1, RC, 8'ha6);
    xfer(1'b1, CC, 8'hfa);
    check(8'(int_ref_sel), 8'h01);
    check(8'({cmp_in_switch, cmp_mode}), 8'h0a);
    check(8'({ladder_en, range_low, tap_sel}), 8'h36);
    rdchk(CC, 8'h0a);
    xfer(1'b1, CC, 8'h03);
    check(8'(int_ref_sel), 8'h00);
    check(8'({cmp_in_switch, cmp_mode}), 8'h03);
    xfer(1'b1, CC, 8'h02);
    $display("t_mode done");
  endtask
  task automatic t_change();
    xfer(1'b1, IC, 8'hc0);
    xfer(1'b1, PE, 8'h40);
    xfer(1'b1, IM, 8'h01);
    xfer(1'b0, IS, 8'h00);
    vin1 <= 7'h00;
    repeat (6) @(posedge pclk);
    check(8'({cpu_irq, irq}), 8'h03);
    rdchk(PF, 8'h40);
    rdchk(CC, 8'h42);
    rdchk(IS, 8'h01);
    check(8'(irq), 8'h00);
    xfer(1'b1, PF, 8'h00);
    check(8'(cpu_irq), 8'h00);
    xfer(1'b1, IM, 8'h00);
    vin2 <= 7'h00;
    repeat (6) @(posedge pclk);
    check(8'({cpu_irq, irq}), 8'h02);
    rdchk(IS, 8'h01);
    $display("t_change done");
  endtask
  task automatic t_unmapped();
    xfer(1'b1, 32'h3f0, 8'hff);
    check(8'(err), 8'h01);
    xfer(1'b0, 32'h3f0, 8'h00);
    check(8'(err), 8'h01);
    $display("t_unmapped done");
  endtask
  task automatic t_reset2();
    xfer(1'b1, RC, 8'he6);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check(8'({ladder_en, range_low, tap_sel, pin_connect}), 8'h00);
    rdchk(RC, 8'h00);
    $display("t_reset2 done");
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // Watchdog
  initial begin
    repeat (5000) @(posedge pclk);
    failures++;
    give_verdict();
  end
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'h1;
    vin1 = 7'h64;
    vin2 = 7'h64;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_ref();
    t_pin();
    t_mode();
    t_change();
    t_unmapped();
    t_reset2();
    give_verdict();
  end
endmodule
`default_nettype wire
